// File: pkg/slot_timing_pkg.sv
// constants, types and timing counts of the slot timing engine
package slot_timing_pkg;

    // main clock and derived tick dividers
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [2:0] DIV_LOW_SPEED = 3'h7;   // divide by 8, 1.25 MHz tick
    localparam logic [2:0] DIV_HIGH_SPEED = 3'h5;  // divide by 6, 1.67 MHz tick

    // sync detection latency limits, in ns, and as clock counts
    localparam int SYNC_DETECT_LATENCY_NS = 10000;
    localparam int SYNC_DETECT_LATENCY_DIS_NS = 7500;
    localparam int SYNC_DETECT_CYCLES = SYNC_DETECT_LATENCY_NS / CLK_PERIOD_NS;
    localparam int SYNC_DETECT_DIS_CYCLES =
        SYNC_DETECT_LATENCY_DIS_NS / CLK_PERIOD_NS;

    // bit and frame lengths in ticks
    localparam logic [4:0] BIT_TICKS_LOW = 5'h10;   // 16
    localparam logic [4:0] BIT_TICKS_HIGH = 5'h0e;  // 14
    localparam logic [8:0] FRAME_10L = 9'h0d0;      // 208
    localparam logic [8:0] FRAME_20L = 9'h190;      // 400
    localparam logic [8:0] FRAME_20H = 9'h15e;      // 350

    // slot start positions in ticks after the sync pulse
    localparam logic [10:0] SLOT1_10L = 11'h058;    // 88
    localparam logic [10:0] SLOT2_10L = 11'h178;    // 376
    localparam logic [10:0] SLOT3_10L = 11'h2ae;    // 686
    localparam logic [10:0] SLOT1_20L = 11'h058;    // 88
    localparam logic [10:0] SLOT2_20L = 11'h21c;    // 540
    localparam logic [10:0] SLOT1_2H = 11'h077;     // 119
    localparam logic [10:0] SLOT2_2H = 11'h23a;     // 570
    localparam logic [10:0] SLOT1_3H = 11'h070;     // 112
    localparam logic [10:0] SLOT2_3H = 11'h1ea;     // 490, slot 2 alone
    localparam logic [10:0] SLOT2_3H_V12 = 11'h1e2; // 482, pair 1 and 2
    localparam logic [10:0] SLOT2_3H_V23 = 11'h20c; // 524, pair 2 and 3
    localparam logic [10:0] SLOT3_3H = 11'h389;     // 905

    // discharge window in ticks after the sync pulse
    localparam logic [10:0] DISCHARGE_BEGIN_DELAY = 11'h027; // 39
    localparam logic [10:0] DISCHARGE_END_DELAY = 11'h050;   // 80

    // asynchronous periods in ticks
    localparam logic [10:0] PERIOD_250 = 11'h1f4;   // 500
    localparam logic [10:0] PERIOD_500 = 11'h3e8;   // 1000
    localparam logic [10:0] CYC_MAX = 11'h7ff;

    // configuration register layout (0x01, 0x11, 0x12)
    localparam logic [7:0] CFG11_MODE_MASK = 8'h3b;
    localparam logic [7:0] CFG11_P10_SYNC = 8'h00;
    localparam logic [7:0] CFG11_A10_500 = 8'h10;
    localparam logic [7:0] CFG11_A10_250 = 8'h30;
    localparam logic [7:0] CFG11_P20_L = 8'h02;
    localparam logic [7:0] CFG11_P20_2H = 8'h03;
    localparam logic [7:0] CFG11_P20_3H = 8'h0b;
    localparam int CFG11_HIRES_BIT = 6;
    localparam int CFG12_DISCHARGE_BIT = 0;
    localparam int CFG12_SLOT_LSB = 3;
    localparam int CFG12_VELOCITY_BIT = 6;
    localparam int CFG01_ENABLE_BIT = 0;

    // decoded protocol mode
    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_P10,
        MODE_A10_250,
        MODE_A10_500,
        MODE_P20_L,
        MODE_P20_2H,
        MODE_P20_3H
    } mode_t;

endpackage

// File: logic/tick_divider.sv
// clock enable divider producing a one-cycle tick every div_in+1 clocks
`timescale 1ns/1ps
module tick_divider (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic clr_in,
    input wire logic [2:0] div_in,
    output logic tick_out
);

    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t div_q;
    div_state_t div_d;

    // count up to the terminal value, then emit one tick
    always_comb begin
        div_d = div_q;
        div_d.tick = 1'b0;
        if (clr_in) begin
            div_d.cnt = 3'h0;
        end else if (div_q.cnt == div_in) begin
            div_d.cnt = 3'h0;
            div_d.tick = 1'b1;
        end else begin
            div_d.cnt = div_q.cnt + 3'h1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    assign tick_out = div_q.tick;

endmodule

// File: logic/psi5_slot_timing_engine.sv
// transmit slot and bit timing engine of a sensor-side psi5 link
`timescale 1ns/1ps
module psi5_slot_timing_engine (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic sync_pulse_in,
    input wire logic [7:0] cfg_reg01_in,
    input wire logic [7:0] cfg_reg11_in,
    input wire logic [7:0] cfg_reg12_in,
    output logic frame_active_out,
    output logic frame_start_out,
    output logic bit_strobe_out,
    output logic [4:0] bit_index_out,
    output logic [1:0] slot_out,
    output logic discharge_out,
    output logic high_speed_out
);

    typedef enum logic [1:0] {
        PH_OFF,
        PH_WAIT,
        PH_SEND
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic sync_ff1;
        logic sync_ff2;
        logic sync_prev;
        logic [10:0] cyc_cnt;
        logic [8:0] frame_cnt;
        logic [4:0] bit_cnt;
        logic [4:0] bit_idx;
        logic [1:0] slot_no;
        logic frame_active;
        logic frame_start;
        logic bit_strobe;
        logic discharge;
        logic high_speed;
    } engine_state_t;

    engine_state_t st_q;
    engine_state_t st_d;

    logic tick_low;
    logic tick_high;
    logic tick;
    logic tick_clr;
    logic sync_edge;
    slot_timing_pkg::mode_t mode;
    logic is_async;
    logic hs;
    logic hires;
    logic velocity;
    logic discharge_en;
    logic [1:0] slot_field;
    logic [10:0] start_a;
    logic [10:0] start_b;
    logic start_b_valid;
    logic [1:0] slot_a;
    logic [1:0] slot_b;
    logic [8:0] frame_len;
    logic [4:0] bit_len;
    logic [10:0] period;
    logic [10:0] cyc_next;

    // derived tick enables, restarted on every sync in the synchronous modes so slots align to it
    tick_divider u_tick_low (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .clr_in(tick_clr),
        .div_in(slot_timing_pkg::DIV_LOW_SPEED),
        .tick_out(tick_low)
    );

    tick_divider u_tick_high (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .clr_in(tick_clr),
        .div_in(slot_timing_pkg::DIV_HIGH_SPEED),
        .tick_out(tick_high)
    );

    // decode the protocol mode from the configuration bytes
    always_comb begin
        mode = slot_timing_pkg::MODE_OFF;
        if (cfg_reg01_in[slot_timing_pkg::CFG01_ENABLE_BIT]) begin
            case (cfg_reg11_in & slot_timing_pkg::CFG11_MODE_MASK)
                slot_timing_pkg::CFG11_P10_SYNC: begin
                    mode = slot_timing_pkg::MODE_P10;
                end
                slot_timing_pkg::CFG11_A10_500: begin
                    mode = slot_timing_pkg::MODE_A10_500;
                end
                slot_timing_pkg::CFG11_A10_250: begin
                    mode = slot_timing_pkg::MODE_A10_250;
                end
                slot_timing_pkg::CFG11_P20_L: begin
                    mode = slot_timing_pkg::MODE_P20_L;
                end
                slot_timing_pkg::CFG11_P20_2H: begin
                    mode = slot_timing_pkg::MODE_P20_2H;
                end
                slot_timing_pkg::CFG11_P20_3H: begin
                    mode = slot_timing_pkg::MODE_P20_3H;
                end
                default: begin
                    mode = slot_timing_pkg::MODE_OFF;
                end
            endcase
        end
    end

    // option bits and speed class
    assign hires = cfg_reg11_in[slot_timing_pkg::CFG11_HIRES_BIT];
    assign velocity = cfg_reg12_in[slot_timing_pkg::CFG12_VELOCITY_BIT];
    assign discharge_en = cfg_reg12_in[slot_timing_pkg::CFG12_DISCHARGE_BIT]
        && (mode == slot_timing_pkg::MODE_P10);
    assign slot_field = cfg_reg12_in[slot_timing_pkg::CFG12_SLOT_LSB +: 2];
    assign is_async = (mode == slot_timing_pkg::MODE_A10_250)
        || (mode == slot_timing_pkg::MODE_A10_500);
    assign hs = (mode == slot_timing_pkg::MODE_P20_2H)
        || (mode == slot_timing_pkg::MODE_P20_3H);
    assign tick = hs ? tick_high : tick_low;
    assign period = (mode == slot_timing_pkg::MODE_A10_250) ?
        slot_timing_pkg::PERIOD_250 : slot_timing_pkg::PERIOD_500;

    // frame and bit lengths per speed class and format
    always_comb begin
        bit_len = slot_timing_pkg::BIT_TICKS_LOW;
        frame_len = slot_timing_pkg::FRAME_20L;
        if (hs) begin
            bit_len = slot_timing_pkg::BIT_TICKS_HIGH;
            frame_len = slot_timing_pkg::FRAME_20H;
        end else if (mode != slot_timing_pkg::MODE_P20_L) begin
            frame_len = slot_timing_pkg::FRAME_10L;
        end
    end

    // slot start positions for the programmed slot, and an optional second
    always_comb begin
        start_a = slot_timing_pkg::SLOT1_10L;
        start_b = slot_timing_pkg::SLOT2_10L;
        start_b_valid = 1'b0;
        slot_a = 2'h1;
        slot_b = 2'h2;
        case (mode)
            slot_timing_pkg::MODE_P10: begin
                if (slot_field == 2'h1) begin
                    start_a = slot_timing_pkg::SLOT2_10L;
                    start_b = slot_timing_pkg::SLOT3_10L;
                    slot_a = 2'h2;
                    slot_b = 2'h3;
                end else if (slot_field == 2'h2) begin
                    start_a = slot_timing_pkg::SLOT3_10L;
                    slot_a = 2'h3;
                end else begin
                    start_a = slot_timing_pkg::SLOT1_10L;
                end
                start_b_valid = hires && (slot_field != 2'h2);
            end
            slot_timing_pkg::MODE_P20_L: begin
                if (slot_field == 2'h1 && !velocity) begin
                    start_a = slot_timing_pkg::SLOT2_20L;
                    slot_a = 2'h2;
                end else begin
                    start_a = slot_timing_pkg::SLOT1_20L;
                end
                start_b = slot_timing_pkg::SLOT2_20L;
                start_b_valid = velocity;
            end
            slot_timing_pkg::MODE_P20_2H: begin
                if (slot_field == 2'h1 && !velocity) begin
                    start_a = slot_timing_pkg::SLOT2_2H;
                    slot_a = 2'h2;
                end else begin
                    start_a = slot_timing_pkg::SLOT1_2H;
                end
                start_b = slot_timing_pkg::SLOT2_2H;
                start_b_valid = velocity;
            end
            slot_timing_pkg::MODE_P20_3H: begin
                if (!velocity) begin
                    case (slot_field)
                        2'h1: begin
                            start_a = slot_timing_pkg::SLOT2_3H;
                            slot_a = 2'h2;
                        end
                        2'h2: begin
                            start_a = slot_timing_pkg::SLOT3_3H;
                            slot_a = 2'h3;
                        end
                        default: begin
                            start_a = slot_timing_pkg::SLOT1_3H;
                        end
                    endcase
                end else begin
                    start_b_valid = 1'b1;
                    case (slot_field)
                        2'h2: begin
                            start_a = slot_timing_pkg::SLOT2_3H_V23;
                            start_b = slot_timing_pkg::SLOT3_3H;
                            slot_a = 2'h2;
                            slot_b = 2'h3;
                        end
                        2'h3: begin
                            start_a = slot_timing_pkg::SLOT1_3H;
                            start_b = slot_timing_pkg::SLOT3_3H;
                            slot_b = 2'h3;
                        end
                        default: begin
                            start_a = slot_timing_pkg::SLOT1_3H;
                            start_b = slot_timing_pkg::SLOT2_3H_V12;
                        end
                    endcase
                end
            end
            default: begin
                start_b_valid = 1'b0;
            end
        endcase
    end

    // rising edge of the synchronised sync pulse
    assign sync_edge = st_q.sync_ff2 && !st_q.sync_prev;
    assign tick_clr = (st_q.phase == PH_OFF)
        || (sync_edge && !is_async);
    assign cyc_next = (st_q.cyc_cnt == slot_timing_pkg::CYC_MAX) ?
        st_q.cyc_cnt : st_q.cyc_cnt + 11'h001;

    // sequencing of slot starts, frame and bit timing and discharge
    always_comb begin
        st_d = st_q;
        st_d.sync_ff1 = sync_pulse_in;
        st_d.sync_ff2 = st_q.sync_ff1;
        st_d.sync_prev = st_q.sync_ff2;
        st_d.frame_start = 1'b0;
        st_d.bit_strobe = 1'b0;
        st_d.high_speed = hs;
        if (mode == slot_timing_pkg::MODE_OFF) begin
            st_d.phase = PH_OFF;
            st_d.frame_active = 1'b0;
            st_d.discharge = 1'b0;
            st_d.cyc_cnt = slot_timing_pkg::CYC_MAX;
        end else if (st_q.phase == PH_OFF) begin
            // first tick after enabling starts an async frame at once
            st_d.phase = is_async ? PH_WAIT : PH_OFF;
            st_d.cyc_cnt = is_async ? period - 11'h001 :
                slot_timing_pkg::CYC_MAX;
            if (!is_async && sync_edge) begin
                st_d.phase = PH_WAIT;
                st_d.cyc_cnt = 11'h000;
            end
        end else if (sync_edge && !is_async) begin
            // abort any running frame and restart slot timing
            st_d.phase = PH_WAIT;
            st_d.frame_active = 1'b0;
            st_d.discharge = 1'b0;
            st_d.cyc_cnt = 11'h000;
        end else if (tick) begin
            if (is_async) begin
                // free-running period counter
                st_d.cyc_cnt = (st_q.cyc_cnt >= period - 11'h001) ?
                    11'h000 : st_q.cyc_cnt + 11'h001;
            end else begin
                st_d.cyc_cnt = cyc_next;
            end
            // discharge window after the sync pulse
            st_d.discharge = discharge_en
                && cyc_next >= slot_timing_pkg::DISCHARGE_BEGIN_DELAY
                && cyc_next < slot_timing_pkg::DISCHARGE_END_DELAY;
            if (st_q.phase == PH_SEND) begin
                if (st_q.frame_cnt == frame_len - 9'h001) begin
                    st_d.phase = PH_WAIT;
                    st_d.frame_active = 1'b0;
                end else begin
                    st_d.frame_cnt = st_q.frame_cnt + 9'h001;
                    if (st_q.bit_cnt == bit_len - 5'h01) begin
                        st_d.bit_cnt = 5'h00;
                        st_d.bit_idx = st_q.bit_idx + 5'h01;
                        st_d.bit_strobe = 1'b1;
                    end else begin
                        st_d.bit_cnt = st_q.bit_cnt + 5'h01;
                    end
                end
            end else if ((is_async && st_d.cyc_cnt == 11'h000)
                || (!is_async && cyc_next == start_a)
                || (!is_async && start_b_valid && cyc_next == start_b)) begin
                // frame start, on a slot position or a period boundary
                st_d.phase = PH_SEND;
                st_d.frame_active = 1'b1;
                st_d.frame_start = 1'b1;
                st_d.bit_strobe = 1'b1;
                st_d.frame_cnt = 9'h000;
                st_d.bit_cnt = 5'h00;
                st_d.bit_idx = 5'h00;
                st_d.slot_no = is_async ? 2'h0 :
                    ((cyc_next == start_a) ? slot_a : slot_b);
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign frame_active_out = st_q.frame_active;
    assign frame_start_out = st_q.frame_start;
    assign bit_strobe_out = st_q.bit_strobe;
    assign bit_index_out = st_q.bit_idx;
    assign slot_out = st_q.slot_no;
    assign discharge_out = st_q.discharge;
    assign high_speed_out = st_q.high_speed;

endmodule

// File: tb/psi5_slot_timing_monitor.sv
// assertion checker bound to the slot timing engine ports
`timescale 1ns/1ps
module psi5_slot_timing_monitor (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic sync_pulse_in,
    input wire logic [7:0] cfg_reg01_in,
    input wire logic [7:0] cfg_reg11_in,
    input wire logic [7:0] cfg_reg12_in,
    input wire logic frame_active_out,
    input wire logic frame_start_out,
    input wire logic bit_strobe_out,
    input wire logic [4:0] bit_index_out,
    input wire logic [1:0] slot_out,
    input wire logic discharge_out,
    input wire logic high_speed_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    logic [7:0] mode_s;
    logic hs_mode, async_mode;
    logic [13:0] flen, act_q, gap_q, fs_gap_q, dis_q;
    logic [1:0] age_q;
    logic fs_seen_q;
    // mode decode and expected frame length in main clocks
    assign mode_s = cfg_reg11_in & slot_timing_pkg::CFG11_MODE_MASK;
    assign hs_mode = mode_s == slot_timing_pkg::CFG11_P20_2H ||
        mode_s == slot_timing_pkg::CFG11_P20_3H;
    assign async_mode = mode_s == slot_timing_pkg::CFG11_A10_250 ||
        mode_s == slot_timing_pkg::CFG11_A10_500;
    assign flen = (mode_s == slot_timing_pkg::CFG11_P20_L) ? 14'h0c80 :
        (hs_mode ? 14'h0834 : 14'h0680);
    // cycle counters since the last strobe, start and while high
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            act_q <= 14'h0000;
            gap_q <= 14'h0000;
            fs_gap_q <= 14'h0000;
            dis_q <= 14'h0000;
            age_q <= 2'h0;
            fs_seen_q <= 1'b0;
        end else begin
            act_q <= frame_active_out ? act_q + 14'h0001 : 14'h0000;
            gap_q <= bit_strobe_out ? 14'h0001 : gap_q + 14'h0001;
            fs_gap_q <= frame_start_out ? 14'h0001 : fs_gap_q + 14'h0001;
            dis_q <= discharge_out ? dis_q + 14'h0001 : 14'h0000;
            age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
            fs_seen_q <= fs_seen_q | frame_start_out;
        end
    end
    start_shape_a: assert property (frame_start_out |->
        frame_active_out && bit_strobe_out && bit_index_out == 5'h00)
        else $error("frame start without active, strobe or index zero");
    bit_gap_a: assert property (bit_strobe_out &&
        !frame_start_out |-> gap_q == (high_speed_out ? 14'h0054 : 14'h0080))
        else $error("bit strobe spacing wrong");
    frame_len_a: assert property (frame_active_out |->
        act_q < flen)
        else $error("frame active longer than frame length");
    speed_class_a: assert property (age_q == 2'h3 |->
        high_speed_out == hs_mode)
        else $error("speed class does not follow mode");
    async_period_a: assert property (async_mode &&
        frame_start_out && fs_seen_q |-> fs_gap_q ==
        ((mode_s == slot_timing_pkg::CFG11_A10_250) ? 14'h0fa0 : 14'h1f40))
        else $error("asynchronous frame period wrong");
    async_slot_a: assert property (frame_start_out &&
        async_mode |-> slot_out == 2'h0)
        else $error("slot number given in asynchronous mode");
    sync_slot_a: assert property (frame_start_out && !async_mode |->
        slot_out != 2'h0)
        else $error("no slot number in synchronous mode");
    dis_cause_a: assert property (discharge_out |->
        cfg_reg12_in[0] && !frame_active_out &&
        mode_s == slot_timing_pkg::CFG11_P10_SYNC)
        else $error("discharge outside its mode or during a frame");
    dis_len_a: assert property (discharge_out |-> dis_q < 14'h0148)
        else $error("discharge window too long");
    sync_abort_a: assert property ($rose(sync_pulse_in) &&
        frame_active_out && !async_mode && cfg_reg01_in[0] |->
        ##[1:8] !frame_active_out)
        else $error("frame not aborted by new sync pulse");
endmodule
bind psi5_slot_timing_engine psi5_slot_timing_monitor mon_i (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sync_pulse_in(sync_pulse_in),
    .cfg_reg01_in(cfg_reg01_in), .cfg_reg11_in(cfg_reg11_in),
    .cfg_reg12_in(cfg_reg12_in), .frame_active_out(frame_active_out),
    .frame_start_out(frame_start_out), .bit_strobe_out(bit_strobe_out),
    .bit_index_out(bit_index_out), .slot_out(slot_out),
    .discharge_out(discharge_out), .high_speed_out(high_speed_out)
);

// File: tb/ecu_sync_model.sv
// controller side model that issues synchronization pulses
`timescale 1ns/1ps
module ecu_sync_model #(
    parameter int PULSE_CYCLES = 30,
    parameter int MIN_GAP_CYCLES = 2500 // 250 us of the 100 ns clock
) (
    input wire logic ref_clk_in,
    input wire logic fire_in,
    output logic ready_out,
    output logic sync_pulse_out
);
    int width_q = 0;
    int gap_q = MIN_GAP_CYCLES;
    // one pulse of fixed width per request, pulse starts kept apart
    always_ff @(posedge ref_clk_in) begin
        if (fire_in && ready_out) begin
            width_q <= PULSE_CYCLES;
            gap_q <= 1;
        end else begin
            width_q <= (width_q != 0) ? width_q - 1 : 0;
            gap_q <= (gap_q < MIN_GAP_CYCLES) ? gap_q + 1 : gap_q;
        end
    end
    // a new pulse only once the minimum spacing has run out
    assign ready_out = width_q == 0 && gap_q >= MIN_GAP_CYCLES;
    // line idles low between pulses
    assign sync_pulse_out = width_q != 0;
endmodule

// File: tb/psi5_slot_timing_engine_bench.sv
// self-checking bench of the slot timing engine
`timescale 1ns/1ps
module psi5_slot_timing_engine_bench;
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic fire = 1'b0;
    logic sync_pin;
    logic ecu_ready;
    logic [7:0] cfg01 = 8'h01;
    logic [7:0] cfg11 = 8'h00;
    logic [7:0] cfg12 = 8'h00;
    logic fa, fs, bs, dis, hs;
    logic [4:0] bidx;
    logic [1:0] slot;
    int miscompares = 0;
    int checks_done = 0;
    always #50 ref_clk_in = ~ref_clk_in;
    ecu_sync_model ecu (.ref_clk_in(ref_clk_in), .fire_in(fire),
        .ready_out(ecu_ready), .sync_pulse_out(sync_pin));
    psi5_slot_timing_engine DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .sync_pulse_in(sync_pin), .cfg_reg01_in(cfg01), .cfg_reg11_in(cfg11),
        .cfg_reg12_in(cfg12), .frame_active_out(fa), .frame_start_out(fs),
        .bit_strobe_out(bs), .bit_index_out(bidx), .slot_out(slot),
        .discharge_out(dis), .high_speed_out(hs));
    task automatic print_verdict();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // counts within a tolerance, flags by case equality
    task automatic check(string what, int exp, int got, int tol);
        checks_done++;
        if (got < exp - tol || got > exp + tol) begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic check_bits(string what, logic [1:0] exp, logic [1:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic apply(logic [7:0] a, logic [7:0] b);
        @(posedge ref_clk_in);
        cfg11 <= a;
        cfg12 <= b;
        nrst_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
    endtask
    task automatic fire_sync();
        @(posedge ref_clk_in);
        while (ecu_ready !== 1'b1) begin
            @(posedge ref_clk_in);
        end
        fire <= 1'b1;
        @(posedge ref_clk_in);
        fire <= 1'b0;
    endtask
    // cycles from now until the k-th frame start
    task automatic wait_start(int k, output int n);
        n = 0;
        while (k > 0 && n < 12000) begin
            @(negedge ref_clk_in);
            n++;
            if (fs === 1'b1) k--;
        end
    endtask
    task automatic high_len(ref logic sig, output int m);
        m = 1;
        while (m < 4000) begin
            @(negedge ref_clk_in);
            if (sig !== 1'b1) break;
            m++;
        end
    endtask
    // one sync pulse, then start offset, slot, class and frame length
    task automatic sync_run(logic [7:0] a, logic [7:0] b, int k, int t,
        int div, int len, logic [1:0] s);
        int n;
        int m;
        apply(a, b);
        fire_sync();
        wait_start(k, n);
        check("slot start", t * div + 5, n, 4);
        check_bits("slot", s, slot);
        check_bits("speed class", {1'b0, div == 6}, {1'b0, hs});
        high_len(fa, m);
        check("frame length", len * div, m, 1);
    endtask
    task automatic test_p10();
        sync_run(8'h00, 8'h00, 1, 88, 8, 208, 2'h1);
        sync_run(8'h00, 8'h08, 1, 376, 8, 208, 2'h2);
        sync_run(8'h00, 8'h10, 1, 686, 8, 208, 2'h3);
        sync_run(8'h40, 8'h00, 2, 376, 8, 208, 2'h2);
    endtask
    task automatic test_20bit();
        sync_run(8'h02, 8'h00, 1, 88, 8, 400, 2'h1);
        sync_run(8'h02, 8'h08, 1, 540, 8, 400, 2'h2);
        sync_run(8'h03, 8'h00, 1, 119, 6, 350, 2'h1);
        sync_run(8'h03, 8'h48, 2, 570, 6, 350, 2'h2);
        sync_run(8'h0b, 8'h08, 1, 490, 6, 350, 2'h2);
        sync_run(8'h0b, 8'h48, 2, 482, 6, 350, 2'h2);
        sync_run(8'h0b, 8'h50, 1, 524, 6, 350, 2'h2);
        sync_run(8'h0b, 8'h10, 1, 905, 6, 350, 2'h3);
    endtask
    task automatic test_discharge();
        int n;
        int m;
        apply(8'h00, 8'h09);
        fire_sync();
        n = 0;
        while (dis !== 1'b1 && n < 2000) begin
            @(negedge ref_clk_in);
            n++;
        end
        check("discharge begin", 39 * 8 + 5, n, 4);
        high_len(dis, m);
        check("discharge width", 41 * 8, m, 1);
    endtask
    task automatic test_abort();
        int n;
        int m;
        apply(8'h00, 8'h08);
        fire_sync();
        wait_start(1, n);
        repeat (400) @(negedge ref_clk_in);
        fire_sync();
        m = 0;
        while (fa === 1'b1 && m < 50) begin
            @(negedge ref_clk_in);
            m++;
        end
        check("abort delay", 5, m, 3);
        wait_start(1, n);
        check("restart start", 376 * 8 + 5, n + m, 4);
        // clearing the enable stops the running frame at once
        @(posedge ref_clk_in);
        cfg01 <= 8'h00;
        repeat (2) @(negedge ref_clk_in);
        check_bits("disabled frame", 2'h0, {1'b0, fa});
        @(posedge ref_clk_in);
        cfg01 <= 8'h01;
    endtask
    task automatic test_async(logic [7:0] a, int period);
        int n;
        apply(a, 8'h00);
        wait_start(1, n);
        check("first async start", 8, n, 8);
        fire_sync();
        wait_start(1, n);
        check("async period", period * 8, n + 2, 1);
        check_bits("async slot", 2'h0, slot);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        test_p10();
        test_20bit();
        test_discharge();
        test_abort();
        test_async(8'h30, 500);
        test_async(8'h10, 1000);
        print_verdict();
    end
    // hang guard longer than the whole sequence
    initial begin
        repeat (95000) @(posedge ref_clk_in);
        miscompares++;
        print_verdict();
    end
endmodule
